// *** src/micro_port_pkg.sv ***
// Constants, types and states shared by the microprocessor access port
package micro_port_pkg;
  // Bus widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // Address that reaches the internal register space; reads of it cost one extra cycle
  localparam logic [ADDR_W-1:0] INTERNAL_ADDR = 3'h0;
  // Edges from the detecting edge N to the answer edge
  localparam int LAT_INTERNAL = 3;
  localparam int LAT_OTHER = 2;
  localparam int LAT_WRITE0 = 2;
  localparam int LAT_WRITE1 = 3;
  localparam int CNT_W = 2;
  // Mode pin levels
  localparam logic MODE_RDWR = 1'b0;
  localparam logic MODE_DSACK = 1'b1;
  // Reset values
  localparam logic MODE_RESET = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 3'h0;

  // Host-side pins, sampled on clk_sys
  typedef struct packed {
    logic chip_select_n;
    logic rw_wr_n;
    logic data_strobe_n;
    logic [ADDR_W-1:0] host_addr;
    logic [DATA_W-1:0] host_data;
  } host_pins_t;

  // Request towards the internal register space
  typedef struct packed {
    logic wr_stb;
    logic rd_stb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  // Port sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b10
  } port_state_t;
endpackage : micro_port_pkg

// *** src/micro_port_handshake.sv ***
// Synchronous 8-bit microprocessor access port with two handshake styles
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RULE1] Mode pin picks handshake style
// [RULE2] Shared strobe: data strobe or read
// [RULE3] All inputs sampled on rising edges
// [RULE4] Accesses only while chip select low
// [RULE5] Mode 0 ready drops combinationally
// [RULE6] Mode 0 read ready: N+3 internal, N+2
// [RULE7] Mode 0 write ready at N+2
// [RULE8] Host may hold read strobes to continue
// [RULE9] Host ends read by raising chip select
// [RULE10] Host may hold write strobes low
// [RULE11] Write ends on sampled chip select high
// [RULE12] Next write may start right after
// [RULE13] Mode 1 write acknowledge at N+3
// [RULE14] Mode 1 read ack: N+3 internal, N+2
// [RULE15] Read ends, acknowledge forced high
// [RULE16] Reset returns port to idle
// [RULE17] Data driven only on selected reads
// [RULE18] Write address and data captured at N
module micro_port_handshake #(
  parameter int ADDR_WIDTH = micro_port_pkg::ADDR_W,
  parameter int DATA_WIDTH = micro_port_pkg::DATA_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic mode_pin,
  input wire micro_port_pkg::host_pins_t host_in,
  output logic [micro_port_pkg::DATA_W-1:0] host_data_out,
  output logic host_data_oe,
  output logic access_done,
  output logic transfer_ack_n,
  output micro_port_pkg::reg_req_t reg_req,
  input wire logic [micro_port_pkg::DATA_W-1:0] reg_rdata
);
  import micro_port_pkg::*;

  // Widths are fixed by the struct carriers; counts must fit the counter
  initial begin
    if (ADDR_WIDTH != ADDR_W) begin
      $error("micro_port_handshake: address width must match the package");
    end
    if (DATA_WIDTH != DATA_W) begin
      $error("micro_port_handshake: data width must match the package");
    end
    if (LAT_INTERNAL < 1 || LAT_INTERNAL > (1 << CNT_W)) begin
      $error("micro_port_handshake: internal read latency does not fit the counter");
    end
    if (LAT_OTHER < 1 || LAT_OTHER > (1 << CNT_W)) begin
      $error("micro_port_handshake: read latency does not fit the counter");
    end
    if (LAT_WRITE0 < 1 || LAT_WRITE0 > (1 << CNT_W)) begin
      $error("micro_port_handshake: ready write latency does not fit the counter");
    end
    if (LAT_WRITE1 < 1 || LAT_WRITE1 > (1 << CNT_W)) begin
      $error("micro_port_handshake: acknowledge write latency does not fit the counter");
    end
  end

  port_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic mode_meta_q, mode_q;
  logic is_read_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic wr_stb_q, rd_stb_q;

  // Mode pin is static but asynchronous, so it is synchronised.
  // Only the second flop is read; a change takes two edges to show,
  // so the host must leave the port idle while the pin moves.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_meta_q <= MODE_RESET;
      mode_q <= MODE_RESET;
    end else begin
      mode_meta_q <= mode_pin;
      mode_q <= mode_meta_q;
    end
  end

  // Host is logic on clk_sys, so its pins are read without a synchroniser.
  // A synchroniser here would add two edges and break the fixed latencies;
  // the host must meet setup and hold to clk_sys instead.
  // Read wins when a read and a write level are both present.
  wire logic selected = !host_in.chip_select_n; // [RULE4]
  wire logic m0_read = !host_in.data_strobe_n && host_in.rw_wr_n; // [RULE2]
  wire logic m0_write = !host_in.rw_wr_n;
  wire logic m1_strobe = !host_in.data_strobe_n; // [RULE2]
  wire logic mode_ack = (mode_q == MODE_DSACK); // [RULE1]
  wire logic strobe_read = mode_ack ? (m1_strobe && host_in.rw_wr_n) : m0_read;
  wire logic strobe_write = mode_ack ? (m1_strobe && !host_in.rw_wr_n) : m0_write;
  wire logic start_read = selected && strobe_read;
  wire logic start_write = selected && strobe_write && !strobe_read;
  wire logic start = (state_q == ST_IDLE) && (start_read || start_write);
  wire logic addr_internal = (host_in.host_addr == INTERNAL_ADDR);

  // Edges to wait after N; internal reads cost one more edge
  wire logic [CNT_W-1:0] lat_read = addr_internal ? CNT_W'(LAT_INTERNAL - 1) : CNT_W'(LAT_OTHER - 1); // [RULE6] [RULE14]
  wire logic [CNT_W-1:0] lat_write = mode_ack ? CNT_W'(LAT_WRITE1 - 1) : CNT_W'(LAT_WRITE0 - 1); // [RULE7] [RULE13]
  wire logic [CNT_W-1:0] lat_load = start_read ? lat_read : lat_write;

  // Sequencer: one access per chip-select assertion.
  // IDLE waits for edge N, BUSY counts down to the answer edge,
  // DONE holds the answer until an edge samples chip select high.
  // Strobes seen while BUSY or DONE are ignored, not queued.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin // [RULE3]
          state_d = ST_BUSY;
          cnt_d = lat_load;
        end
      end
      ST_BUSY: begin
        if (cnt_q == '0) begin
          state_d = ST_DONE;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_DONE: begin
        // Held strobes keep the answer; only chip select high ends it
        if (!selected) begin // [RULE8] [RULE9] [RULE10] [RULE11] [RULE15]
          state_d = ST_IDLE; // [RULE12]
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State, counter and access kind
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE; // [RULE16]
      cnt_q <= '0;
      is_read_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (start) begin
        is_read_q <= start_read;
      end
    end
  end

  // Address and write data taken on the detecting edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= ADDR_RESET;
      wdata_q <= DATA_RESET;
    end else if (start) begin
      addr_q <= host_in.host_addr; // [RULE18]
      wdata_q <= host_in.host_data; // [RULE18]
    end
  end

  // One-cycle strobes towards the register space, the cycle after N.
  // Registered so that the register space sees clean pulses,
  // at the cost of one edge inside the fixed latency.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
    end else begin
      wr_stb_q <= start && start_write;
      rd_stb_q <= start && start_read;
    end
  end

  // Last BUSY cycle: the next edge is the answer edge
  wire logic answer_edge = (state_q == ST_BUSY) && (cnt_q == '0);

  // Read data latched as the answer is given, so it holds while strobes stay.
  // The register space must present its data by then; later changes
  // are not seen until the next access.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= DATA_RESET;
    end else if (answer_edge && is_read_q) begin
      rdata_q <= reg_rdata;
    end
  end

  // Ready falls at once on strobe and select; no clock edge in the path.
  // It rises again from the DONE state register, or at once without a
  // clock if select or strobe goes away first. Held strobes in DONE keep it high.
  // The unused handshake output rests at its inactive level.
  wire logic done = (state_q == ST_DONE);
  wire logic m0_busy = selected && (m0_read || m0_write) && !done; // [RULE5]
  assign access_done = mode_ack ? 1'b1 : !m0_busy; // [RULE5] [RULE6] [RULE7]
  assign transfer_ack_n = mode_ack ? !done : 1'b1; // [RULE13] [RULE14] [RULE15] [RULE11]

  // Bus drive only for a selected read; the pad resolves the rest.
  // Enable follows select and strobe levels without a clock, so the
  // bus is released as soon as the host raises chip select.
  assign host_data_oe = selected && strobe_read; // [RULE17]
  assign host_data_out = rdata_q;

  // Request towards the register space, all from flops
  assign reg_req.wr_stb = wr_stb_q;
  assign reg_req.rd_stb = rd_stb_q;
  assign reg_req.addr = addr_q;
  assign reg_req.wdata = wdata_q;
endmodule : micro_port_handshake

`default_nettype wire

// *** tb/reg_space_model.sv ***
// Register space stand-in
`timescale 1ns/1ps
`default_nettype none
module reg_space_model (
  input wire logic clk_sys,
  input wire micro_port_pkg::reg_req_t reg_req,
  output logic [micro_port_pkg::DATA_W-1:0] reg_rdata
);
  import micro_port_pkg::*;
  // Last written byte, whatever the address
  always_ff @(posedge clk_sys) if (reg_req.wr_stb) reg_rdata <= reg_req.wdata;
endmodule : reg_space_model
`default_nettype wire

// *** tb/micro_port_assertions.sv ***
// Handshake timing checker
`timescale 1ns/1ps
`default_nettype none
module micro_port_assertions (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic mode_pin,
  input wire micro_port_pkg::host_pins_t host_in,
  input wire logic access_done,
  input wire logic transfer_ack_n
);
  import micro_port_pkg::*;
  logic cs_q;
  // Edge N marker and strobe levels
  always_ff @(posedge clk_sys) cs_q <= host_in.chip_select_n;
  wire logic g = cs_q && !host_in.chip_select_n;
  wire logic rd = host_in.rw_wr_n && !host_in.data_strobe_n;
  wire logic wr = !host_in.rw_wr_n;
  wire logic low = host_in.host_addr == INTERNAL_ADDR;
  wire logic ok = mode_pin ? !transfer_ack_n : access_done;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Sampled values lag the answer edge by one
  sequence w3(s); !s[*3] ##1 s; endsequence
  sequence w4(s); !s[*4] ##1 s; endsequence
  chk_ack_mode0: assert property (!mode_pin |-> transfer_ack_n)
    else $error("ack low");
  chk_rdy_mode1: assert property (mode_pin |-> access_done)
    else $error("ready low");
  chk_rdy_drop: assert property (g && !mode_pin && (rd || wr) |-> !access_done)
    else $error("ready high");
  chk_rd_ext: assert property (g && rd && !low |-> w3(ok))
    else $error("late");
  chk_rd_int: assert property (g && rd && low |-> w4(ok))
    else $error("late");
  chk_wr0_rdy: assert property (g && wr && !mode_pin |-> w3(ok))
    else $error("late");
  chk_wr1_ack: assert property (g && wr && mode_pin |-> w4(ok))
    else $error("late");
  chk_ack_release: assert property (!transfer_ack_n && host_in.chip_select_n |=> transfer_ack_n)
    else $error("ack held");
endmodule : micro_port_assertions
bind micro_port_handshake micro_port_assertions checker_i (.clk_sys, .reset_n, .mode_pin, .host_in,
  .access_done, .transfer_ack_n);
`default_nettype wire

// *** tb/micro_port_handshake_tb.sv ***
// Access port bench
`timescale 1ns/1ps
`default_nettype none
module micro_port_handshake_tb;
  import micro_port_pkg::*;
  logic clk_sys = 0, reset_n = 0, mode_pin = 0;
  host_pins_t host_in = '{1'h1, 1'h1, 1'h1, 3'h0, 8'h00};
  logic [7:0] host_data_out, reg_rdata;
  logic host_data_oe, access_done, transfer_ack_n;
  reg_req_t reg_req;
  int mismatches = 0, total_checks = 0;
  micro_port_handshake uut (.clk_sys, .reset_n, .mode_pin, .host_in, .host_data_out, .host_data_oe,
    .access_done, .transfer_ack_n, .reg_req, .reg_rdata);
  reg_space_model partner (.clk_sys, .reg_req, .reg_rdata);
  // Clock, and a watchdog far beyond the 41 cycles needed
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    #3000;
    mismatches++;
    report_and_stop;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s %h %h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Held until answered; released bus shows inverted data
  task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d, input int lat);
    int n;
    n = 0;
    @(posedge clk_sys);
    host_in <= '{1'h0, !wr, wr & !mode_pin, a, d};
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (n < 9 && (mode_pin ? transfer_ack_n : !access_done) === 1'h1);
    chk("edges", 8'(lat + 1), 8'(n));
    chk("data", wr ? 8'h00 : d, host_data_oe ? host_data_out : 8'h00);
    chk("addr", 8'(a), 8'(reg_req.addr));
    chk("wdata", wr ? d : 8'h5a, wr ? reg_req.wdata : 8'h5a);
    @(posedge clk_sys);
    host_in <= '{1'h1, 1'h1, 1'h1, a, ~d};
  endtask : acc
  task automatic t_mode0;
    acc(1, 3'h0, 8'h5a, 2);
    acc(0, 3'h0, 8'h5a, 3);
    acc(0, 3'h5, 8'h5a, 2);
    $display("mode0 done");
  endtask : t_mode0
  // Live switch; mode synchroniser needs two edges
  task automatic t_mode1;
    mode_pin <= 1'h1;
    repeat (3) @(posedge clk_sys);
    acc(1, 3'h7, 8'h3c, 3);
    acc(0, 3'h7, 8'h3c, 2);
    acc(0, 3'h0, 8'h3c, 3);
    $display("mode1 done");
  endtask : t_mode1
  initial begin
    @(posedge clk_sys);
    #1 chk("reset idle", 8'h3, 8'({access_done, transfer_ack_n}));
    @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (3) @(posedge clk_sys);
    t_mode0;
    t_mode1;
    report_and_stop;
  end
endmodule : micro_port_handshake_tb
`default_nettype wire
